// ==== core/csc_agu.sv ====
/*
  Address generator: linear, circular and optional bit-reversed pointer
  update. Assumes base and step come from the instruction decoder.
*/
`timescale 1ns/100ps
`default_nettype none
module csc_agu #(
  parameter bit BREV_OK = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [15:0] base,
  input wire logic [15:0] step,
  input wire logic mod_en,
  input wire logic [15:0] mod_start,
  input wire logic [15:0] mod_end,
  input wire logic brev_en,
  input wire logic [15:0] brev_mod,
  output logic [15:0] ptr
);
  logic [15:0] ptr_q;
  logic [15:0] ptr_d;
  logic [15:0] lin;
  logic [15:0] rev_sum;
  logic fwd;

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : rev16

  assign fwd = ~step[15];
  assign lin = base + step;
  assign rev_sum = rev16(rev16(base) + rev16(brev_mod));
  // circular wrap at either end of the buffer
  assign ptr_d = (BREV_OK && brev_en) ? rev_sum :
    (mod_en && fwd && base == mod_end) ? mod_start :
    (mod_en && !fwd && base == mod_start) ? mod_end : lin;
  assign ptr = ptr_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 16'h0000;
    end else if (go) begin
      ptr_q <= ptr_d;
    end
  end

  property p_agu_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
      go && mod_en && !(BREV_OK && brev_en) && fwd && base == mod_end
      |=> ptr_q == $past(mod_start);
  endproperty
  a_agu_wrap: assert property (p_agu_wrap)
    else $error("circular buffer did not wrap to its start");
endmodule : csc_agu
`default_nettype wire

// ==== core/csc_core.sv ====
/*
  CPU status word, core control word, memory-mapped working registers,
  loop start address and the two data-space address generators with the
  program-space window. Assumes every input comes from CPU logic on
  ref_clk; data-space accesses are single-cycle word strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module csc_core
  import csc_pkg::*;
#(
  parameter logic [15:0] XY_SPLIT = CSC_XY_SPLIT_RST
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] ds_addr,
  input wire logic ds_rd,
  input wire logic ds_wr,
  input wire logic [15:0] ds_wdata,
  output logic [15:0] ds_rdata,
  input wire logic [1:0] ctx_sel,
  input wire logic [4:0] alu_flag_we,
  input wire logic alu_byte,
  input wire logic [15:0] alu_result,
  input wire logic [15:0] alu_carry,
  input wire logic acc_ovf_we,
  input wire logic acc_ovf_a,
  input wire logic acc_ovf_b,
  input wire logic acc_sat_a,
  input wire logic acc_sat_b,
  input wire logic do_active,
  input wire logic rep_active,
  input wire logic [2:0] do_level,
  input wire logic stack_frame_act,
  input wire logic nesting_disable,
  input wire logic ipl_we,
  input wire logic [3:0] ipl_new,
  input wire logic lstart_we,
  input wire logic [22:0] lstart_addr,
  input wire csc_amode_type am_mode,
  input wire logic [5:0] am_group,
  output logic am_legal,
  input wire logic agu_go,
  input wire logic dual_fetch,
  input wire logic [15:0] x_base,
  input wire logic [15:0] x_step,
  input wire logic x_mod_en,
  input wire logic [15:0] x_mod_start,
  input wire logic [15:0] x_mod_end,
  input wire logic x_brev_en,
  input wire logic [15:0] brev_mod,
  input wire logic [15:0] y_base,
  input wire logic [15:0] y_step,
  input wire logic y_mod_en,
  input wire logic [15:0] y_mod_start,
  input wire logic [15:0] y_mod_end,
  output logic [15:0] x_ptr,
  output logic [15:0] y_ptr,
  output logic x_in_ds,
  output logic y_in_yblk,
  input wire logic psv_en,
  input wire logic [7:0] psv_page,
  output logic psv_hit,
  output logic [21:0] prog_word_addr,
  output logic [15:0] sr_out,
  output logic [15:0] cc_out,
  output logic user_irq_off,
  output logic edt_pulse
);
  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  wire w_hit = ds_addr < CSC_W_END;
  wire [3:0] w_idx = ds_addr[4:1];
  wire sr_wr = ds_wr && ds_addr == CSC_SR_OFF;
  wire cc_wr = ds_wr && ds_addr == CSC_CC_OFF;

  logic [15:0] wf_q [CSC_NCTX][CSC_NW];
  logic [15:0] w15_q;
  logic [15:0] rdata_q;
  logic [15:0] rd_mux;
  logic [22:0] lstart_q;
  logic [15:0] cc_q;
  logic [3:0] ipl_q;
  logic [4:0] flg_q;
  logic oa_q;
  logic ob_q;
  logic edt_q;
  logic sa;
  logic sb;
  logic [1:0] ctx;

  // ---------------------------------------------------------------
  // working registers per context, W15 shared by all contexts
  // ---------------------------------------------------------------
  // a reserved context code falls back to the default set
  assign ctx = (ctx_sel < 2'(CSC_NCTX)) ? ctx_sel : 2'h0;
  wire [15:0] w_rd = (w_idx == CSC_W15_IDX) ? w15_q : wf_q[ctx][w_idx];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < CSC_NCTX; c++) begin
        for (int i = 0; i < CSC_NW; i++) begin
          wf_q[c][i] <= 16'h0000;
        end
      end
      w15_q <= 16'h0000;
    end else if (ds_wr && w_hit) begin
      if (w_idx == CSC_W15_IDX) begin
        w15_q <= ds_wdata;
      end else begin
        wf_q[ctx][w_idx] <= ds_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // loop start address, loaded by the loop hardware only
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lstart_q <= 23'h000000;
    end else if (lstart_we) begin
      lstart_q <= lstart_addr;
    end
  end

  // ---------------------------------------------------------------
  // ALU flags
  // ---------------------------------------------------------------
  wire [3:0] msb = alu_byte ? 4'h7 : 4'hF;
  wire dc_v = alu_byte ? alu_carry[3] : alu_carry[7];
  wire c_v = alu_carry[msb];
  wire n_v = alu_result[msb];
  wire ov_v = alu_carry[msb] ^ alu_carry[msb - 4'h1];
  wire z_v = alu_byte ? alu_result[7:0] == 8'h00
                      : alu_result == 16'h0000;
  wire [4:0] flg_v = {dc_v, n_v, ov_v, z_v, c_v};
  wire [4:0] flg_w = {ds_wdata[SR_DC], ds_wdata[SR_N], ds_wdata[SR_OV],
                      ds_wdata[SR_Z], ds_wdata[SR_C]};

  // the executing instruction's result beats a same-cycle store
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flg_q <= SR_RST[4:0];
    end else begin
      for (int k = 0; k < 5; k++) begin
        if (alu_flag_we[k]) begin
          flg_q[k] <= flg_v[k];
        end else if (sr_wr) begin
          flg_q[k] <= flg_w[k];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // accumulator overflow and clip
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oa_q <= 1'b0;
      ob_q <= 1'b0;
    end else if (acc_ovf_we) begin
      oa_q <= acc_ovf_a;
      ob_q <= acc_ovf_b;
    end else if (sr_wr) begin
      oa_q <= ds_wdata[SR_OA];
      ob_q <= ds_wdata[SR_OB];
    end
  end

  // clearing the combined bit clears both; whole-word writes are the
  // only safe way to touch these, bit operations race the hardware
  wire sab_clr = sr_wr && !ds_wdata[SR_SAB];

  csc_sticky u_clip_a (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .set (acc_sat_a),
    .wr_en (sr_wr),
    .wr_val (ds_wdata[SR_SA]),
    .clr (sab_clr),
    .q (sa)
  );

  csc_sticky u_clip_b (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .set (acc_sat_b),
    .wr_en (sr_wr),
    .wr_val (ds_wdata[SR_SB]),
    .clr (sab_clr),
    .q (sb)
  );

  // ---------------------------------------------------------------
  // priority level and core control
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ipl_q <= 4'h0;
    end else if (ipl_we) begin
      ipl_q <= ipl_new;
    end else begin
      if (sr_wr && !nesting_disable) begin
        ipl_q[2:0] <= ds_wdata[SR_IPL +: 3];
      end
      if (cc_wr && !ds_wdata[CC_PRIORITY_LEVEL_TOP_BIT]) begin
        ipl_q[3] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cc_q <= CC_RST;
      edt_q <= 1'b0;
    end else begin
      edt_q <= cc_wr && ds_wdata[CC_EDT];
      if (cc_wr) begin
        cc_q <= ds_wdata & CC_RW_MASK;
      end
    end
  end

  assign user_irq_off = ipl_q[3] || ipl_q[2:0] == CSC_IPL_ALL;
  assign edt_pulse = edt_q;

  // ---------------------------------------------------------------
  // register read view
  // ---------------------------------------------------------------
  assign sr_out = {oa_q, ob_q, sa, sb,
                   oa_q | ob_q,
                   sa | sb,
                   do_active,
                   flg_q[FE_DC], ipl_q[2:0],
                   rep_active,
                   flg_q[FE_N], flg_q[FE_OV], flg_q[FE_Z], flg_q[FE_C]};
  // early termination always reads back as zero
  assign cc_out = cc_q | {5'h00, do_level, 4'h0,
                          ipl_q > CSC_IPL_MAX_LOW,
                          stack_frame_act, 2'h0};

  assign rd_mux = w_hit ? w_rd :
    (ds_addr == CSC_SR_OFF) ? sr_out :
    (ds_addr == CSC_CC_OFF) ? cc_out :
    (ds_addr == CSC_LSTART_LO_OFF) ? lstart_q[15:0] :
    (ds_addr == CSC_LSTART_HI_OFF) ? {9'h000, lstart_q[22:16]} :
    16'h0000;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (ds_rd) begin
      rdata_q <= rd_mux;
    end
  end
  assign ds_rdata = rdata_q;

  // ---------------------------------------------------------------
  // addressing: mode group, X and Y generators, program window
  // ---------------------------------------------------------------
  assign am_legal = am_group[am_mode];

  csc_agu #(.BREV_OK(1'b1)) u_x_agu (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .go (agu_go),
    .base (x_base),
    .step (x_step),
    .mod_en (x_mod_en),
    .mod_start (x_mod_start),
    .mod_end (x_mod_end),
    .brev_en (x_brev_en),
    .brev_mod (brev_mod),
    .ptr (x_ptr)
  );

  // Y has no bit-reverse and only moves for dual-operand fetches
  csc_agu #(.BREV_OK(1'b0)) u_y_agu (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .go (agu_go && dual_fetch),
    .base (y_base),
    .step (y_step),
    .mod_en (y_mod_en),
    .mod_start (y_mod_start),
    .mod_end (y_mod_end),
    .brev_en (1'b0),
    .brev_mod (brev_mod),
    .ptr (y_ptr)
  );

  assign x_in_ds = x_ptr < CSC_DS_BYTES;
  assign y_in_yblk = y_ptr >= XY_SPLIT && y_ptr < CSC_DS_BYTES;
  assign psv_hit = psv_en && x_ptr[15];
  assign prog_word_addr = {psv_page, x_ptr[14:1]};

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_w_wr_rd;
    (ds_wr && w_hit) ##1
      (ds_rd && !ds_wr && $stable(ds_addr) && $stable(ctx_sel));
  endsequence
  property p_ctx_rw;
    s_w_wr_rd |=> ds_rdata == $past(ds_wdata, 2);
  endproperty
  a_ctx_rw: assert property (p_ctx_rw)
    else $error("working register readback mismatch");
  property p_lstart_ro;
    !lstart_we && ds_wr |=> $stable(lstart_q);
  endproperty
  a_lstart_ro: assert property (p_lstart_ro)
    else $error("loop start address changed by a store");
  property p_ovf;
    acc_ovf_we |=> sr_out[SR_OA] == $past(acc_ovf_a)
                && sr_out[SR_OB] == $past(acc_ovf_b);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flags did not follow accumulators");
  property p_oab;
    sr_out[SR_OAB] == (sr_out[SR_OA] || sr_out[SR_OB]);
  endproperty
  a_oab: assert property (p_oab)
    else $error("combined overflow bit wrong");
  property p_sab_clr;
    sab_clr && !acc_sat_a && !acc_sat_b
      |=> !sr_out[SR_SA] && !sr_out[SR_SB] && !sr_out[SR_SAB];
  endproperty
  a_sab_clr: assert property (p_sab_clr)
    else $error("clearing combined clip bit left a flag set");
  property p_loops;
    sr_out[SR_DA] == do_active && sr_out[SR_RA] == rep_active;
  endproperty
  a_loops: assert property (p_loops)
    else $error("loop running bits do not track the loops");
  property p_dc;
    alu_flag_we[FE_DC] |=> sr_out[SR_DC] == $past(dc_v);
  endproperty
  a_dc: assert property (p_dc)
    else $error("half carry from wrong bit");
  property p_irq_off;
    ipl_we |=> user_irq_off == ($past(ipl_new[3])
                             || $past(ipl_new[2:0]) == CSC_IPL_ALL);
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("user interrupts not disabled at level seven");
  property p_ipl_ro;
    nesting_disable && !ipl_we |=> $stable(sr_out[SR_IPL +: 3]);
  endproperty
  a_ipl_ro: assert property (p_ipl_ro)
    else $error("priority bits changed under nesting disable");
  property p_nzcv;
    alu_flag_we[FE_N] && alu_flag_we[FE_C] && alu_flag_we[FE_OV]
      |=> sr_out[SR_N] == $past(n_v) && sr_out[SR_C] == $past(c_v)
       && sr_out[SR_OV] == $past(ov_v);
  endproperty
  a_nzcv: assert property (p_nzcv)
    else $error("negative, carry or wrap flag wrong");
  property p_zero;
    alu_flag_we[FE_Z] |=> sr_out[SR_Z] == $past(z_v);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");
  property p_priority_level_top_bit;
    cc_out[CC_PRIORITY_LEVEL_TOP_BIT] == (ipl_q > CSC_IPL_MAX_LOW) && !cc_out[CC_EDT];
  endproperty
  a_priority_level_top_bit: assert property (p_priority_level_top_bit)
    else $error("top priority bit wrong");
  property p_flag_hold;
    alu_flag_we == 5'h00 && !sr_wr |=> $stable(flg_q);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("ALU flags changed without an affecting op");
endmodule : csc_core
`default_nettype wire

// ==== core/csc_sticky.sv ====
/*
  One sticky status flag: set by hardware, written or cleared by
  software. Assumes set, write and clear come from the CPU clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module csc_sticky (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic wr_en,
  input wire logic wr_val,
  input wire logic clr,
  output logic q
);
  logic q_q;
  logic q_d;
  // a saturation in the clearing cycle still lands
  assign q_d = set | (~clr & (wr_en ? wr_val : q_q));
  assign q = q_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

  property p_stk_set;
    @(posedge ref_clk) disable iff (!rst_n) set |=> q_q;
  endproperty
  a_stk_set: assert property (p_stk_set)
    else $error("sticky flag missed a set");
  property p_stk_hold;
    @(posedge ref_clk) disable iff (!rst_n) q_q && !clr && !wr_en |=> q_q;
  endproperty
  a_stk_hold: assert property (p_stk_hold)
    else $error("sticky flag dropped on its own");
endmodule : csc_sticky
`default_nettype wire

// ==== include/csc_pkg.sv ====
/*
  Constants, field positions and types for the CPU status and core
  control block. Assumes a 16-bit data space, byte addressed.
*/
`default_nettype none
package csc_pkg;
  // ---------------------------------------------------------------
  // data space layout
  // ---------------------------------------------------------------
  localparam logic [15:0] CSC_DS_BYTES = 16'h0800;
  localparam logic [15:0] CSC_XY_SPLIT_RST = 16'h0400;
  localparam logic [15:0] CSC_W_END = 16'h0020;
  localparam logic [15:0] CSC_LSTART_LO_OFF = 16'h0036;
  localparam logic [15:0] CSC_LSTART_HI_OFF = 16'h0038;
  localparam logic [15:0] CSC_SR_OFF = 16'h0042;
  localparam logic [15:0] CSC_CC_OFF = 16'h0044;
  localparam int CSC_NCTX = 3;
  localparam int CSC_NW = 15;
  localparam logic [3:0] CSC_W15_IDX = 4'hF;
  localparam logic [3:0] CSC_IPL_MAX_LOW = 4'h7;
  localparam logic [2:0] CSC_IPL_ALL = 3'h7;
  // ---------------------------------------------------------------
  // status word fields
  // ---------------------------------------------------------------
  localparam int SR_OA = 15;
  localparam int SR_OB = 14;
  localparam int SR_SA = 13;
  localparam int SR_SB = 12;
  localparam int SR_OAB = 11;
  localparam int SR_SAB = 10;
  localparam int SR_DA = 9;
  localparam int SR_DC = 8;
  localparam int SR_IPL = 5;
  localparam int SR_RA = 4;
  localparam int SR_N = 3;
  localparam int SR_OV = 2;
  localparam int SR_Z = 1;
  localparam int SR_C = 0;
  // ---------------------------------------------------------------
  // core control word fields
  // ---------------------------------------------------------------
  localparam int CC_EDT = 11;
  localparam int CC_DL = 8;
  localparam int CC_PRIORITY_LEVEL_TOP_BIT = 3;
  localparam int CC_SFA = 2;
  localparam logic [15:0] CC_RW_MASK = 16'hB0F3;
  localparam logic [15:0] CC_RST = 16'h0020;
  localparam logic [15:0] SR_RST = 16'h0000;
  // ---------------------------------------------------------------
  // flag update enables and addressing modes
  // ---------------------------------------------------------------
  localparam int FE_C = 0;
  localparam int FE_Z = 1;
  localparam int FE_OV = 2;
  localparam int FE_N = 3;
  localparam int FE_DC = 4;
  typedef enum logic [2:0] {
    AM_INHERENT, AM_RELATIVE, AM_LITERAL,
    AM_MEM_DIRECT, AM_REG_DIRECT, AM_REG_INDIRECT
  } csc_amode_type;
endpackage : csc_pkg
`default_nettype wire

// ==== verification/tb.sv ====
/*
  Self-checking bench for the status and core control block.
  Assumes one-cycle register writes and reads, and live loop bits.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import csc_pkg::*;
  logic ref_clk, rst_n, ds_rd, ds_wr, alu_byte, acc_ovf_we, acc_ovf_a;
  logic acc_ovf_b, acc_sat_a, acc_sat_b, do_active, rep_active;
  logic stack_frame_act, nesting_disable, ipl_we, lstart_we, agu_go;
  logic dual_fetch, x_mod_en, x_brev_en, y_mod_en, psv_en;
  logic am_legal, user_irq_off, x_in_ds, y_in_yblk, psv_hit, edt_pulse;
  logic [21:0] prog_word_addr;
  logic [1:0] ctx_sel;
  logic [2:0] do_level;
  logic [3:0] ipl_new;
  logic [4:0] alu_flag_we;
  logic [5:0] am_group;
  logic [7:0] psv_page;
  logic [22:0] lstart_addr;
  csc_amode_type am_mode;
  logic [15:0] ds_addr, ds_wdata, alu_result, alu_carry, x_base, x_step;
  logic [15:0] x_mod_start, x_mod_end, brev_mod, y_base, y_step;
  logic [15:0] y_mod_start, y_mod_end, ds_rdata, x_ptr, sr_out, cc_out;
  logic [15:0] q, y_ptr;
  int miscompares = 0;
  int samples_checked = 0;

  csc_core i_dut (
    .ref_clk, .rst_n, .ds_addr, .ds_rd, .ds_wr, .ds_wdata, .ds_rdata,
    .ctx_sel, .alu_flag_we, .alu_byte, .alu_result, .alu_carry,
    .acc_ovf_we, .acc_ovf_a, .acc_ovf_b, .acc_sat_a, .acc_sat_b,
    .do_active, .rep_active, .do_level, .stack_frame_act,
    .nesting_disable, .ipl_we, .ipl_new, .lstart_we, .lstart_addr,
    .am_mode, .am_group, .am_legal, .agu_go, .dual_fetch, .x_base,
    .x_step, .x_mod_en, .x_mod_start, .x_mod_end, .x_brev_en, .brev_mod,
    .y_base, .y_step, .y_mod_en, .y_mod_start, .y_mod_end, .x_ptr,
    .y_ptr, .x_in_ds, .y_in_yblk, .psv_en, .psv_page, .psv_hit,
    .prog_word_addr, .sr_out, .cc_out, .user_irq_off, .edt_pulse
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // one word access; the strobe is dropped at the edge that takes it
  task automatic bus(input logic w, input logic [1:0] c,
                     input logic [15:0] a, d, output logic [15:0] rq);
    @(posedge ref_clk);
    ds_wr <= w;
    ds_rd <= !w;
    ctx_sel <= c;
    ds_addr <= a;
    ds_wdata <= d;
    @(posedge ref_clk);
    ds_wr <= 1'b0;
    ds_rd <= 1'b0;
    #1 rq = ds_rdata;
  endtask : bus

  task automatic alu(input logic [4:0] we, input logic b,
                     input logic [15:0] r, c, exp);
    @(posedge ref_clk);
    alu_flag_we <= we;
    alu_byte <= b;
    alu_result <= r;
    alu_carry <= c;
    @(posedge ref_clk);
    alu_flag_we <= 5'h00;
    #1 chk("alu flags", sr_out & 16'h010F, exp);
  endtask : alu

  task automatic ovf(input logic a, b, input logic [15:0] exp);
    @(posedge ref_clk);
    acc_ovf_we <= 1'b1;
    acc_ovf_a <= a;
    acc_ovf_b <= b;
    @(posedge ref_clk);
    acc_ovf_we <= 1'b0;
    #1 chk("acc overflow", sr_out & 16'hC800, exp);
  endtask : ovf

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_flags;
    alu(5'h1F, 1'b0, 16'h8000, 16'h8080, 16'h010D);
    alu(5'h02, 1'b0, 16'h0000, 16'h0000, 16'h010F);
    alu(5'h1F, 1'b1, 16'h0001, 16'h0008, 16'h0100);
  endtask : t_flags

  task automatic t_sticky;
    ovf(1'b1, 1'b0, 16'h8800);
    ovf(1'b0, 1'b1, 16'h4800);
    ovf(1'b0, 1'b0, 16'h0000);
    @(posedge ref_clk);
    acc_sat_a <= 1'b1;
    @(posedge ref_clk);
    acc_sat_a <= 1'b0;
    acc_sat_b <= 1'b1;
    @(posedge ref_clk);
    acc_sat_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("clip held", sr_out & 16'h3400, 16'h3400);
    // whole-word write, never a bit operation on the clip flags
    bus(1'b1, 2'h0, 16'h0042, 16'h0210, q);
    chk("clip cleared", sr_out & 16'h3610, 16'h0000);
  endtask : t_sticky

  task automatic t_loops;
    @(posedge ref_clk);
    do_active <= 1'b1;
    do_level <= 3'h5;
    stack_frame_act <= 1'b1;
    @(posedge ref_clk);
    #1 chk("do running", sr_out & 16'h0210, 16'h0200);
    chk("loop level", cc_out & 16'h0704, 16'h0504);
    do_active <= 1'b0;
    rep_active <= 1'b1;
    @(posedge ref_clk);
    #1 chk("repeat running", sr_out & 16'h0210, 16'h0010);
  endtask : t_loops

  task automatic t_ipl;
    bus(1'b1, 2'h0, 16'h0042, 16'h00E0, q);
    chk("level 7", sr_out & 16'h00E0, 16'h00E0);
    chk("irq off 111", {15'h0, user_irq_off}, 16'h0001);
    nesting_disable <= 1'b1;
    bus(1'b1, 2'h0, 16'h0042, 16'h0000, q);
    chk("level locked", sr_out & 16'h00E0, 16'h00E0);
    nesting_disable <= 1'b0;
    bus(1'b1, 2'h0, 16'h0042, 16'h0000, q);
    chk("irq on", {15'h0, user_irq_off}, 16'h0000);
    @(posedge ref_clk);
    ipl_we <= 1'b1;
    ipl_new <= 4'h8;
    @(posedge ref_clk);
    ipl_we <= 1'b0;
    #1 chk("top level bit", cc_out & 16'h0008, 16'h0008);
    chk("irq off top", {15'h0, user_irq_off}, 16'h0001);
    // a zero in the top level bit clears it; early stop is a pulse only
    bus(1'b1, 2'h0, 16'h0044, 16'h0800, q);
    chk("early stop pulse", {15'h0, edt_pulse}, 16'h0001);
    chk("top bit cleared", cc_out & 16'h0808, 16'h0000);
    chk("irq on again", {15'h0, user_irq_off}, 16'h0000);
  endtask : t_ipl

  task automatic t_regs;
    @(posedge ref_clk);
    lstart_we <= 1'b1;
    lstart_addr <= 23'h123456;
    @(posedge ref_clk);
    lstart_we <= 1'b0;
    bus(1'b1, 2'h0, 16'h0036, 16'hFFFF, q);
    bus(1'b1, 2'h0, 16'h0038, 16'hFFFF, q);
    bus(1'b0, 2'h0, 16'h0036, 16'h0000, q);
    chk("loop start lo", q, 16'h3456);
    bus(1'b0, 2'h0, 16'h0038, 16'h0000, q);
    chk("loop start hi", q, 16'h0012);
    bus(1'b1, 2'h1, 16'h0000, 16'hAAAA, q);
    bus(1'b1, 2'h0, 16'h0000, 16'h5555, q);
    bus(1'b0, 2'h1, 16'h0000, 16'h0000, q);
    chk("w0 set 1", q, 16'hAAAA);
    bus(1'b0, 2'h0, 16'h0000, 16'h0000, q);
    chk("w0 default", q, 16'h5555);
    bus(1'b0, 2'h0, 16'h0100, 16'h0000, q);
    chk("unmapped", q, 16'h0000);
    // store then load on the next edge, no idle cycle between
    @(posedge ref_clk);
    ds_wr <= 1'b1;
    ctx_sel <= 2'h2;
    ds_addr <= 16'h0004;
    ds_wdata <= 16'h1234;
    @(posedge ref_clk);
    ds_wr <= 1'b0;
    ds_rd <= 1'b1;
    @(posedge ref_clk);
    ds_rd <= 1'b0;
    #1 chk("w2 set 2", ds_rdata, 16'h1234);
  endtask : t_regs

  task automatic t_addr;
    am_mode <= AM_LITERAL;
    am_group <= 6'h04;
    @(posedge ref_clk);
    #1 chk("mode allowed", {15'h0, am_legal}, 16'h0001);
    am_group <= 6'h3B;
    @(posedge ref_clk);
    #1 chk("mode refused", {15'h0, am_legal}, 16'h0000);
    agu_go <= 1'b1;
    @(posedge ref_clk);
    agu_go <= 1'b0;
    #1 chk("modulo wrap", x_ptr, 16'h0100);
    chk("y idle", y_ptr, 16'h0000);
    chk("x in base", {15'h0, x_in_ds}, 16'h0001);
    chk("no window", {15'h0, psv_hit}, 16'h0000);
    x_mod_en <= 1'b0;
    x_base <= 16'h8002;
    x_step <= 16'h0004;
    y_base <= 16'h0400;
    y_step <= 16'h0002;
    dual_fetch <= 1'b1;
    psv_en <= 1'b1;
    psv_page <= 8'hA5;
    agu_go <= 1'b1;
    @(posedge ref_clk);
    agu_go <= 1'b0;
    #1 chk("x linear", x_ptr, 16'h8006);
    chk("y dual", y_ptr, 16'h0402);
    chk("y block", {15'h0, y_in_yblk}, 16'h0001);
    chk("x past base", {15'h0, x_in_ds}, 16'h0000);
    chk("window hit", {15'h0, psv_hit}, 16'h0001);
    chk("window page", {8'h00, prog_word_addr[21:14]}, 16'h00A5);
    chk("window word", {2'h0, prog_word_addr[13:0]}, 16'h0003);
  endtask : t_addr

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    $display("FAIL watchdog expected end seen timeout");
    final_report();
  end

  initial begin
    {rst_n, ds_rd, ds_wr, alu_byte, acc_ovf_we, acc_ovf_a, acc_ovf_b,
     acc_sat_a, acc_sat_b, do_active, rep_active, stack_frame_act,
     nesting_disable, ipl_we, lstart_we, agu_go, dual_fetch, x_brev_en,
     y_mod_en, psv_en, ctx_sel, do_level, ipl_new, alu_flag_we,
     am_group, psv_page, lstart_addr, ds_addr, ds_wdata, alu_result,
     alu_carry, brev_mod, y_base, y_step, y_mod_start, y_mod_end} = '0;
    am_mode = AM_INHERENT;
    // base sits on the end so the first step must wrap
    x_mod_en = 1'b1;
    x_base = 16'h0110;
    x_step = 16'h0002;
    x_mod_start = 16'h0100;
    x_mod_end = 16'h0110;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk("status reset", sr_out, 16'h0000);
    chk("control reset", cc_out, 16'h0020);
    t_flags();
    t_sticky();
    t_loops();
    t_ipl();
    t_regs();
    t_addr();
    final_report();
  end
endmodule : tb
`default_nettype wire
